// ==== src/hbd_pkg.sv ====
// constants for the half-bridge serial control decoder
package hbd_pkg;
  localparam int WORD_BITS = 16;
  localparam int CNT_W = 5;
  localparam logic [CNT_W-1:0] FULL_CNT = 5'h10;
  localparam logic [CNT_W-1:0] MAX_CNT = 5'h1f;
  localparam int NUM_BRIDGES = 10;
  localparam int NUM_LOW = 6;
  localparam int NUM_HIGH = 4;
  localparam int SYNC_STAGES = 2;
  localparam int SYNC_W = 3 + 2 * NUM_BRIDGES + 2;
  // control word fields
  localparam int CLR_BIT = 15;
  localparam int ADDR_BIT = 14;
  localparam int OLSD_BIT = 13;
  localparam int ACT_LSB = 7;
  localparam int CONF_LSB = 1;
  // status word fields
  localparam int ST_OC_BIT = 15;
  localparam int ST_PSF_BIT = 14;
  localparam int ST_OL_BIT = 13;
  localparam int ST_TW_BIT = 0;
  localparam logic [WORD_BITS-1:0] WORD_RST = 16'h0000;
  localparam logic [NUM_LOW-1:0] LOW_RST = 6'h00;
  localparam logic [NUM_HIGH-1:0] HIGH_RST = 4'h0;
  localparam logic [NUM_BRIDGES-1:0] BR_RST = 10'h000;
  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_FRAME = 1'b1
  } frame_state_t;
endpackage

// ==== src/hbd_sync.sv ====
// multi-bit two-stage synchroniser for asynchronous inputs
`timescale 1ns/100ps
module hbd_sync #(
  parameter int W = 1,
  parameter int STAGES = 2
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // async in, synced out
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] hold_ff;

  if (STAGES != 2 || W < 1) begin : g_bad_param
    $error("hbd_sync: only two stages and W >= 1 supported");
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      meta_ff <= '0;
      hold_ff <= '0;
    end else begin
      meta_ff <= async_in;
      hold_ff <= meta_ff;
    end
  end

  assign sync_out = hold_ff;
endmodule // hbd_sync

// ==== src/half_bridge_spi_control_decoder.sv ====
// serial control decoder and output steering for ten half-bridges
`timescale 1ns/100ps
module half_bridge_spi_control_decoder
  import hbd_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // serial link pins
  input wire logic serial_clk,
  input wire logic chip_select_n,
  input wire logic serial_data_in,
  output logic serial_data_out,
  output logic serial_data_out_en,
  // fault detectors, bit 0 is bridge 1
  input wire logic [NUM_BRIDGES-1:0] openload_detect,
  input wire logic [NUM_BRIDGES-1:0] overcurrent_detect,
  input wire logic supply_fail,
  input wire logic temp_warning,
  // switch drives, bit 0 is bridge 1
  output logic [NUM_BRIDGES-1:0] high_side_switch,
  output logic [NUM_BRIDGES-1:0] low_side_switch
);
  logic [SYNC_W-1:0] sync_w;
  logic sclk_s, sel_s, sdi_s, psf_s, tw_s;
  logic [NUM_BRIDGES-1:0] ol_det_s, oc_det_s;
  logic sclk_d_ff, sel_d_ff;
  frame_state_t state_ff, nxt_state;
  logic [WORD_BITS-1:0] rx_ff, nxt_rx, tx_ff, nxt_tx;
  logic [CNT_W-1:0] cnt_ff, nxt_cnt;
  logic sdo_ff, nxt_sdo, sdo_en_ff, nxt_sdo_en;
  logic addr_sel_ff, nxt_addr_sel;
  logic [NUM_LOW-1:0] act0_ff, nxt_act0, conf0_ff, nxt_conf0;
  logic [NUM_HIGH-1:0] act1_ff, nxt_act1, conf1_ff, nxt_conf1;
  logic olsd0_ff, nxt_olsd0, olsd1_ff, nxt_olsd1;
  logic [NUM_BRIDGES-1:0] ol_lat_ff, nxt_ol_lat, oc_lat_ff, nxt_oc_lat;
  logic [NUM_BRIDGES-1:0] hs_ff, nxt_hs, ls_ff, nxt_ls;
  logic sclk_rise, sclk_fall, cs_fall, cs_rise, apply_w;
  logic [NUM_BRIDGES-1:0] act_vec, conf_vec, olsd_vec, kill_vec;
  logic [NUM_BRIDGES-1:0] clr_vec;
  logic [WORD_BITS-1:0] status0_w, status1_w;

  hbd_sync #(
    .W(SYNC_W),
    .STAGES(SYNC_STAGES)
  ) u_sync (
    .core_clk(core_clk),
    .rst(rst),
    // select inverted: synchroniser reset level then means deselected
    .async_in({serial_clk, ~chip_select_n, serial_data_in, supply_fail,
               temp_warning, openload_detect, overcurrent_detect}),
    .sync_out(sync_w)
  );

  assign {sclk_s, sel_s, sdi_s, psf_s, tw_s, ol_det_s, oc_det_s} = sync_w;
  assign sclk_rise = sclk_s && !sclk_d_ff;
  assign sclk_fall = !sclk_s && sclk_d_ff;
  assign cs_fall = sel_s && !sel_d_ff;
  assign cs_rise = !sel_s && sel_d_ff;
  // word acts only on a complete frame at deselect
  assign apply_w = (state_ff == ST_FRAME) && cs_rise
                   && (cnt_ff == FULL_CNT);

  assign act_vec = {act1_ff, act0_ff};
  assign conf_vec = {conf1_ff, conf0_ff};
  assign olsd_vec = {{NUM_HIGH{olsd1_ff}}, {NUM_LOW{olsd0_ff}}};
  assign kill_vec = oc_lat_ff | (ol_lat_ff & olsd_vec);

  assign status0_w = {oc_lat_ff[NUM_LOW-1:0] != '0, psf_s,
                      ol_lat_ff[NUM_LOW-1:0] != '0, act0_ff, conf0_ff, tw_s};
  assign status1_w = {oc_lat_ff[NUM_BRIDGES-1:NUM_LOW] != '0, psf_s,
                      ol_lat_ff[NUM_BRIDGES-1:NUM_LOW] != '0, 2'b00,
                      act1_ff, 2'b00, conf1_ff, tw_s};

  // serial frame engine
  always_comb begin
    nxt_state = state_ff;
    nxt_rx = rx_ff;
    nxt_tx = tx_ff;
    nxt_cnt = cnt_ff;
    nxt_sdo = sdo_ff;
    nxt_sdo_en = sdo_en_ff;
    case (state_ff)
      ST_IDLE: begin
        if (cs_fall) begin
          // status snapshot for the address of the last complete frame
          nxt_tx = addr_sel_ff ? status1_w : status0_w;
          nxt_sdo = addr_sel_ff ? status1_w[WORD_BITS-1]
                                : status0_w[WORD_BITS-1];
          nxt_sdo_en = 1'b1;
          nxt_cnt = '0;
          nxt_state = ST_FRAME;
        end
      end
      ST_FRAME: begin
        if (cs_rise) begin
          nxt_sdo_en = 1'b0;
          nxt_sdo = 1'b0;
          nxt_state = ST_IDLE;
        end else begin
          if (sclk_fall) begin
            nxt_rx = {rx_ff[WORD_BITS-2:0], sdi_s};
            if (cnt_ff != MAX_CNT) begin
              nxt_cnt = cnt_ff + 5'h01;
            end
          end
          if (sclk_rise) begin
            nxt_sdo = tx_ff[WORD_BITS-1];
            nxt_tx = {tx_ff[WORD_BITS-2:0], 1'b0};
          end
        end
      end
      default: begin
        nxt_state = ST_IDLE;
        nxt_sdo_en = 1'b0;
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_ff <= ST_IDLE;
      rx_ff <= WORD_RST;
      tx_ff <= WORD_RST;
      cnt_ff <= '0;
      sdo_ff <= 1'b0;
      sdo_en_ff <= 1'b0;
      sclk_d_ff <= 1'b0;
      sel_d_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      rx_ff <= nxt_rx;
      tx_ff <= nxt_tx;
      cnt_ff <= nxt_cnt;
      sdo_ff <= nxt_sdo;
      sdo_en_ff <= nxt_sdo_en;
      sclk_d_ff <= sclk_s;
      sel_d_ff <= sel_s;
    end
  end

  // control registers, fault latches and switch drive
  always_comb begin
    nxt_addr_sel = addr_sel_ff;
    nxt_act0 = act0_ff;
    nxt_conf0 = conf0_ff;
    nxt_olsd0 = olsd0_ff;
    nxt_act1 = act1_ff;
    nxt_conf1 = conf1_ff;
    nxt_olsd1 = olsd1_ff;
    clr_vec = BR_RST;
    if (apply_w) begin
      nxt_addr_sel = rx_ff[ADDR_BIT];
      if (!rx_ff[ADDR_BIT]) begin
        nxt_olsd0 = rx_ff[OLSD_BIT];
        nxt_act0 = rx_ff[ACT_LSB+NUM_LOW-1:ACT_LSB];
        nxt_conf0 = rx_ff[CONF_LSB+NUM_LOW-1:CONF_LSB];
        if (rx_ff[CLR_BIT]) begin
          clr_vec = {{NUM_HIGH{1'b0}}, {NUM_LOW{1'b1}}};
        end
      end else begin
        nxt_olsd1 = rx_ff[OLSD_BIT];
        nxt_act1 = rx_ff[ACT_LSB+NUM_HIGH-1:ACT_LSB];
        nxt_conf1 = rx_ff[CONF_LSB+NUM_HIGH-1:CONF_LSB];
        if (rx_ff[CLR_BIT]) begin
          clr_vec = {{NUM_HIGH{1'b1}}, {NUM_LOW{1'b0}}};
        end
      end
    end
    // a detection in the clearing cycle stays latched
    nxt_ol_lat = (ol_lat_ff & ~clr_vec) | (ol_det_s & act_vec);
    nxt_oc_lat = (oc_lat_ff & ~clr_vec) | (oc_det_s & act_vec);
    nxt_hs = act_vec & conf_vec & ~kill_vec & {NUM_BRIDGES{!psf_s}};
    nxt_ls = act_vec & ~conf_vec & ~kill_vec & {NUM_BRIDGES{!psf_s}};
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      addr_sel_ff <= 1'b0;
      act0_ff <= LOW_RST;
      conf0_ff <= LOW_RST;
      olsd0_ff <= 1'b0;
      act1_ff <= HIGH_RST;
      conf1_ff <= HIGH_RST;
      olsd1_ff <= 1'b0;
      ol_lat_ff <= BR_RST;
      oc_lat_ff <= BR_RST;
      hs_ff <= BR_RST;
      ls_ff <= BR_RST;
    end else begin
      addr_sel_ff <= nxt_addr_sel;
      act0_ff <= nxt_act0;
      conf0_ff <= nxt_conf0;
      olsd0_ff <= nxt_olsd0;
      act1_ff <= nxt_act1;
      conf1_ff <= nxt_conf1;
      olsd1_ff <= nxt_olsd1;
      ol_lat_ff <= nxt_ol_lat;
      oc_lat_ff <= nxt_oc_lat;
      hs_ff <= nxt_hs;
      ls_ff <= nxt_ls;
    end
  end

  assign serial_data_out = sdo_ff;
  assign serial_data_out_en = sdo_en_ff;
  assign high_side_switch = hs_ff;
  assign low_side_switch = ls_ff;

  // checks
  logic seen_apply_ff;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      seen_apply_ff <= 1'b0;
    end else if (apply_w) begin
      seen_apply_ff <= 1'b1;
    end
  end

  status_clear_a: assert property (@(posedge core_clk) disable iff (rst)
    apply_w && rx_ff[CLR_BIT] && !rx_ff[ADDR_BIT]
    && (ol_det_s[NUM_LOW-1:0] == '0) && (oc_det_s[NUM_LOW-1:0] == '0)
    |=> (ol_lat_ff[NUM_LOW-1:0] == '0) && (oc_lat_ff[NUM_LOW-1:0] == '0))
    else $error("status clear of group low missed");
  low_route_a: assert property (@(posedge core_clk) disable iff (rst)
    apply_w && !rx_ff[ADDR_BIT] |=> act0_ff == $past(rx_ff[12:7])
    && conf0_ff == $past(rx_ff[6:1]) && olsd0_ff == $past(rx_ff[13]))
    else $error("group low word not routed");
  high_route_a: assert property (@(posedge core_clk) disable iff (rst)
    apply_w && rx_ff[ADDR_BIT] |=> act1_ff == $past(rx_ff[10:7])
    && conf1_ff == $past(rx_ff[4:1]))
    else $error("group high word not routed");
  other_hold_a: assert property (@(posedge core_clk) disable iff (rst)
    apply_w && rx_ff[ADDR_BIT] |=> $stable(act0_ff) && $stable(conf0_ff)
    && $stable(olsd0_ff))
    else $error("group low changed by group high word");
  ol_shutdown_a: assert property (@(posedge core_clk) disable iff (rst)
    ##1 (($past(ol_lat_ff & olsd_vec) & (hs_ff | ls_ff)) == '0))
    else $error("open load bridge still driven");
  hiz_off_a: assert property (@(posedge core_clk) disable iff (rst)
    apply_w && !rx_ff[ADDR_BIT] && !rx_ff[ACT_LSB]
    |=> ##1 !hs_ff[0] && !ls_ff[0])
    else $error("inactive bridge one driven");
  level_sel_a: assert property (@(posedge core_clk) disable iff (rst)
    ##1 ((hs_ff & ~$past(act_vec & conf_vec)) == '0)
    && ((ls_ff & ~$past(act_vec & ~conf_vec)) == '0)
    && !(|(hs_ff & ls_ff)))
    else $error("high side drive wrong or both sides on");
  apply_only_a: assert property (@(posedge core_clk) disable iff (rst)
    !apply_w |=> $stable(act1_ff) && $stable(conf1_ff) && $stable(olsd1_ff))
    else $error("group high changed outside deselect");
  addr_next_a: assert property (@(posedge core_clk) disable iff (rst)
    apply_w |=> addr_sel_ff == $past(rx_ff[ADDR_BIT]))
    else $error("status address not taken");
  reset_def_a: assert property (@(posedge core_clk) disable iff (rst)
    !seen_apply_ff |-> !addr_sel_ff && act_vec == '0 && !olsd0_ff
    && !olsd1_ff)
    else $error("reset defaults lost");
  full_frame_a: assert property (@(posedge core_clk) disable iff (rst)
    (state_ff == ST_FRAME) && cs_rise && (cnt_ff != FULL_CNT)
    |=> $stable(act0_ff) && $stable(act1_ff) && $stable(addr_sel_ff)
    && $stable(olsd0_ff) && $stable(olsd1_ff))
    else $error("word applied without full frame");

  low_word_c: cover property (@(posedge core_clk) disable iff (rst)
    apply_w && !rx_ff[ADDR_BIT]);
  high_word_c: cover property (@(posedge core_clk) disable iff (rst)
    apply_w && rx_ff[ADDR_BIT]);
  clear_c: cover property (@(posedge core_clk) disable iff (rst)
    apply_w && rx_ff[CLR_BIT] && (ol_lat_ff != '0));
  shutdown_c: cover property (@(posedge core_clk) disable iff (rst)
    (ol_lat_ff & olsd_vec & act_vec) != '0);
endmodule // half_bridge_spi_control_decoder

// ==== tb/hbd_host.sv ====
// serial host model: one framed word out, status word in
`timescale 1ns/100ps
module hbd_host (
  // serial pins
  output logic serial_clk,
  output logic chip_select_n,
  output logic serial_data_in,
  input wire logic serial_data_out,
  input wire logic serial_data_out_en
);
  logic [15:0] rx;
  logic en_seen;
  initial begin
    en_seen = 1'b0;
    serial_clk = 1'b0;
    chip_select_n = 1'b1;
    serial_data_in = 1'b1;
    rx = 16'h0000;
  end
  // n other than 16 gives a frame the device must refuse
  task automatic xfer(input logic [15:0] w, input int n);
    chip_select_n = 1'b0;
    #80;
    for (int i = 0; i < n; i++) begin
      serial_clk = 1'b1;
      serial_data_in = w[15 - (i % 16)];
      if (i == 15)
        serial_data_in = 1'b0;
      #80;
      serial_clk = 1'b0;
      rx = {rx[14:0], serial_data_out};
      if (i == 0)
        en_seen = serial_data_out_en;
      #80;
    end
    chip_select_n = 1'b1;
    // released line shows no stale value
    serial_data_in = ~serial_data_in;
    #80;
  endtask
endmodule // hbd_host

// ==== tb/tb_half_bridge_spi_control_decoder.sv ====
// self-checking bench for the half-bridge serial control decoder
`timescale 1ns/100ps
module tb_half_bridge_spi_control_decoder;
  import hbd_pkg::*;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic sclk, cs_n, sdi, sdo, sdo_en;
  logic [9:0] openload_detect = 10'h000;
  logic [9:0] overcurrent_detect = 10'h000;
  logic supply_fail = 1'b0;
  logic temp_warning = 1'b0;
  logic [9:0] hs, ls;
  int err_count = 0;
  int samples_checked = 0;
  logic [5:0] act_lo = 6'h00, sel_lo = 6'h00;
  logic [3:0] act_hi = 4'h0, sel_hi = 4'h0;
  logic addr = 1'b0;
  logic [15:0] w, st;
  always #2 core_clk = ~core_clk;
  half_bridge_spi_control_decoder u_dut (
    .core_clk(core_clk), .rst(rst), .serial_clk(sclk),
    .chip_select_n(cs_n), .serial_data_in(sdi),
    .serial_data_out(sdo), .serial_data_out_en(sdo_en),
    .openload_detect(openload_detect),
    .overcurrent_detect(overcurrent_detect),
    .supply_fail(supply_fail), .temp_warning(temp_warning),
    .high_side_switch(hs), .low_side_switch(ls)
  );
  hbd_host u_host (
    .serial_clk(sclk), .chip_select_n(cs_n), .serial_data_in(sdi),
    .serial_data_out(sdo), .serial_data_out_en(sdo_en)
  );
  function automatic logic [15:0] status_of(input logic a, input logic ol);
    if (a)
      return {1'b0, supply_fail, ol, 2'b00, act_hi, 2'b00, sel_hi,
              temp_warning};
    return {1'b0, supply_fail, ol, act_lo, sel_lo, temp_warning};
  endfunction
  task automatic check(input string nm, input logic [15:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // k marks bridges held off by a fault latch or by supply fail
  task automatic check_sw(input logic [9:0] k);
    logic [9:0] eh, el;
    eh = {act_hi & sel_hi, act_lo & sel_lo} & ~k;
    el = {act_hi & ~sel_hi, act_lo & ~sel_lo} & ~k;
    check("high_side", {6'h00, hs}, {6'h00, eh});
    check("low_side", {6'h00, ls}, {6'h00, el});
  endtask
  task automatic frame(input logic [15:0] wd, input int n);
    u_host.xfer(wd, n);
    if (n == 16) begin
      addr = wd[14];
      if (wd[14]) begin
        act_hi = wd[10:7];
        sel_hi = wd[4:1];
      end else begin
        act_lo = wd[12:7];
        sel_lo = wd[6:1];
      end
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    #200000;
    err_count++;
    end_sim();
  end
  initial begin
    void'($urandom(32'h27be4471));
    repeat (20) @(negedge core_clk);
    rst = 1'b0;
    repeat (4) @(negedge core_clk);
    check_sw(10'h000);
    for (int i = 0; i < 16; i++) begin
      w = 16'($urandom);
      temp_warning = w[0];
      st = status_of(addr, 1'b0);
      repeat (4) @(negedge core_clk);
      frame(w, 16);
      check("status", u_host.rx, st);
      check("sdo_en_on", {15'h0000, u_host.en_seen}, 16'h0001);
      check("sdo_en_off", {15'h0000, sdo_en}, 16'h0000);
      check_sw(10'h000);
    end
    $display("test random words done");
    frame(16'h0000, 16);
    for (int n = 15; n <= 17; n += 2) begin
      frame(16'h7ffe, n);
      check_sw(10'h000);
    end
    st = status_of(addr, 1'b0);
    frame(16'h0000, 16);
    check("status_addr", u_host.rx, st);
    $display("test refused frames done");
    frame(16'h3f80, 16);
    openload_detect = 10'h001;
    repeat (8) @(negedge core_clk);
    openload_detect = 10'h000;
    repeat (4) @(negedge core_clk);
    check_sw(10'h001);
    st = status_of(1'b0, 1'b1);
    frame(16'hbf80, 16);
    check("status_ol", u_host.rx, st);
    check_sw(10'h000);
    frame(16'h1f80, 16);
    openload_detect = 10'h001;
    repeat (8) @(negedge core_clk);
    openload_detect = 10'h000;
    repeat (4) @(negedge core_clk);
    check_sw(10'h000);
    st = status_of(1'b0, 1'b1);
    frame(16'h1f80, 16);
    check("status_keep", u_host.rx, st);
    $display("test open load done");
    overcurrent_detect = 10'h002;
    repeat (8) @(negedge core_clk);
    overcurrent_detect = 10'h000;
    repeat (4) @(negedge core_clk);
    check_sw(10'h002);
    st = status_of(1'b0, 1'b1) | 16'h8000;
    frame(16'h9f80, 16);
    check("status_oc", u_host.rx, st);
    check_sw(10'h000);
    supply_fail = 1'b1;
    repeat (8) @(negedge core_clk);
    check_sw(10'h3ff);
    st = status_of(1'b0, 1'b0);
    frame(16'h1f80, 16);
    check("status_psf", u_host.rx, st);
    supply_fail = 1'b0;
    repeat (8) @(negedge core_clk);
    check_sw(10'h000);
    $display("test fault latches done");
    end_sim();
  end
endmodule // tb_half_bridge_spi_control_decoder
